// ### rtl/fgr_pkg.sv
// Package for the fast address-line-20 gate and alternate reset port.
// Assumes a single 100 MHz device clock.
`default_nettype none

package fgr_pkg;

	// ------------------------------------------------------------------
	// Port map
	// ------------------------------------------------------------------
	localparam logic [15:0] FGR_PORT_ADDR     = 16'h0092;
	localparam logic [7:0]  FGR_PORT_RESET    = 8'h24;
	localparam int          FGR_CFG_EN_BIT    = 2;
	localparam int          FGR_BIT_ALT_RST   = 0;
	localparam int          FGR_BIT_ALT_ADDR20_GATE   = 1;
	localparam logic [7:0]  FGR_FIXED_MASK    = 8'hFC;
	localparam logic [7:0]  FGR_FIXED_VALUE   = 8'h24;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int RST_DELAY_NS    = 14000;
	localparam int RST_WIDTH_NS    = 6000;
	localparam int RST_DELAY_CYC   =
		(RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_WIDTH_CYC   =
		(RST_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FGR_CNT_W       = 12;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} fgr_io_req_type;

	typedef enum logic [2:0] {
		FGR_IDLE  = 3'b001,
		FGR_DELAY = 3'b010,
		FGR_PULSE = 3'b100
	} fgr_pulse_state_type;

endpackage

`default_nettype wire

// ### rtl/fgr_port.sv
// Fast address-line-20 gate and alternate CPU reset port, top level.
// Assumes host I/O strobes are one-cycle pulses on the device clock and
// the keyboard-controller signals arrive from another domain.
//
// Contract
// - Port decoded only while config enable bit 2 is set.
// - Reserved bits read fixed 0x24 pattern; writes to them ignored.
// - Bit 1 drives alternate A20 gate; reads back last written.
// - Bit 0 clears on system reset; otherwise host read/write.
// - Bit-field text: 500 ns delay, 1 us low pulse; code uses the 14 us delay and 6 us pulse instead.
// - Functional text: at least 14 us delay, 6 us pulse.
// - One pulse per arming; bit 0 must return to 0 first.
// - Alternate reset output inactive high after reset.
// - If enabled, AND alternate and controller resets; set polarity.
// - A20 mask output is OR of controller gate and alternate gate.
// - Alternate A20 gate is low after reset.
// - Controller A20 gate taken from port bit twenty-one.
`default_nettype none

module fgr_port
	import fgr_pkg::*;
#(
	parameter int DELAY_CYC = RST_DELAY_CYC,
	parameter int WIDTH_CYC = RST_WIDTH_CYC
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// Host I/O access
	input  wire fgr_io_req_type io_req_i,
	output logic                io_hit_o,
	output logic [7:0]          io_rdata_o,
	// Configuration
	input  wire logic [7:0]     fast_reset_a20_config_i,
	input  wire logic           kbd_reset_invert_i,
	// Keyboard controller
	input  wire logic           kbc_port_bit_twentyone_i,
	input  wire logic           kbc_reset_n_i,
	// Outputs
	output logic                alt_addr20_gate_o,
	output logic                alt_cpu_reset_n_o,
	output logic                cpu_addr20_mask_n_o,
	output logic                keyboard_reset_out_o
);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic kbc_a20_s;
	logic kbc_rst_s;

	fgr_sync u_sync_a20 (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (kbc_port_bit_twentyone_i),
		.q_o   (kbc_a20_s)
	);

	fgr_sync u_sync_rst (
		.clk_i (clk_i),
		.rst_i (rst_i),
		// Inverted so the synchroniser's reset value means no reset
		.d_i   (~kbc_reset_n_i),
		.q_o   (kbc_rst_s)
	);

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------
	logic       port_en;
	logic       hit;
	logic       a20_reg;
	logic       a20_next;
	logic       rst_bit_reg;
	logic       rst_bit_next;
	logic       arm;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	assign port_en = fast_reset_a20_config_i[FGR_CFG_EN_BIT];
	assign hit     = port_en && (io_req_i.addr == FGR_PORT_ADDR);

	always_comb begin
		a20_next     = a20_reg;
		rst_bit_next = rst_bit_reg;
		rdata_next   = rdata_reg;
		arm          = 1'b0;
		if (hit && io_req_i.wr) begin
			a20_next     = io_req_i.wdata[FGR_BIT_ALT_ADDR20_GATE];
			rst_bit_next = io_req_i.wdata[FGR_BIT_ALT_RST];
			// Only a 0-to-1 change arms a new pulse
			arm = io_req_i.wdata[FGR_BIT_ALT_RST] && !rst_bit_reg;
		end
		if (hit && io_req_i.rd) begin
			rdata_next = (FGR_FIXED_VALUE & FGR_FIXED_MASK)
				| {6'h00, a20_reg, rst_bit_reg};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			a20_reg     <= FGR_PORT_RESET[FGR_BIT_ALT_ADDR20_GATE];
			rst_bit_reg <= FGR_PORT_RESET[FGR_BIT_ALT_RST];
			rdata_reg   <= FGR_PORT_RESET;
		end else begin
			a20_reg     <= a20_next;
			rst_bit_reg <= rst_bit_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign io_hit_o   = hit && (io_req_i.rd || io_req_i.wr);
	assign io_rdata_o = rdata_reg;

	// ------------------------------------------------------------------
	// Alternate reset pulse
	// ------------------------------------------------------------------
	// Functional-text figures are used: they cover the shorter ones too
	logic alt_rst_n;

	fgr_pulse_gen #(
		.DELAY_CYC (DELAY_CYC),
		.WIDTH_CYC (WIDTH_CYC)
	) u_pulse (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.arm_i     (arm),
		.pulse_n_o (alt_rst_n),
		.busy_o    ()
	);

	// ------------------------------------------------------------------
	// Output combination
	// ------------------------------------------------------------------
	logic mask_n_reg;
	logic mask_n_next;
	logic kres_reg;
	logic kres_next;

	always_comb begin
		mask_n_next = kbc_a20_s | a20_reg;
		kres_next   = ~kbc_rst_s;
		if (port_en) begin
			kres_next = alt_rst_n & ~kbc_rst_s;
		end
		kres_next = kres_next ^ kbd_reset_invert_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_n_reg <= 1'b0;
			kres_reg   <= 1'b1;
		end else begin
			mask_n_reg <= mask_n_next;
			kres_reg   <= kres_next;
		end
	end

	assign alt_addr20_gate_o    = a20_reg;
	assign alt_cpu_reset_n_o    = alt_rst_n;
	assign cpu_addr20_mask_n_o  = mask_n_reg;
	assign keyboard_reset_out_o = kres_reg;

endmodule

`default_nettype wire

// ### rtl/fgr_pulse_gen.sv
// Delayed, timed active-low pulse, one per arming.
// Assumes arm_i is a one-cycle pulse on a 0-to-1 write of the reset bit.
`default_nettype none

module fgr_pulse_gen
	import fgr_pkg::*;
#(
	parameter int DELAY_CYC = RST_DELAY_CYC,
	parameter int WIDTH_CYC = RST_WIDTH_CYC
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic arm_i,
	output logic      pulse_n_o,
	output logic      busy_o
);

	fgr_pulse_state_type   state_reg;
	fgr_pulse_state_type   state_next;
	logic [FGR_CNT_W-1:0]  cnt_reg;
	logic [FGR_CNT_W-1:0]  cnt_next;
	logic                  out_n_reg;
	logic                  out_n_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		out_n_next = 1'b1;
		case (state_reg)
			FGR_IDLE: begin
				if (arm_i) begin
					state_next = FGR_DELAY;
					cnt_next   = FGR_CNT_W'(DELAY_CYC - 1);
				end
			end
			FGR_DELAY: begin
				if (cnt_reg == '0) begin
					state_next = FGR_PULSE;
					cnt_next   = FGR_CNT_W'(WIDTH_CYC - 1);
					out_n_next = 1'b0;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			FGR_PULSE: begin
				if (cnt_reg == '0) begin
					state_next = FGR_IDLE;
				end else begin
					cnt_next   = cnt_reg - 1'b1;
					out_n_next = 1'b0;
				end
			end
			default: begin
				state_next = FGR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= FGR_IDLE;
			cnt_reg   <= '0;
			out_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			out_n_reg <= out_n_next;
		end
	end

	assign pulse_n_o = out_n_reg;
	assign busy_o    = (state_reg != FGR_IDLE);

endmodule

`default_nettype wire

// ### rtl/fgr_sync.sv
// Two-flip-flop synchroniser for one level.
// Assumes the input comes from outside the clock domain.
`default_nettype none

module fgr_sync
	import fgr_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Level
	input  wire logic d_i,
	output logic      q_o
);

	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;

endmodule

`default_nettype wire

// ### verification/fgr_host.sv
// Host processor model driving the port's I/O strobes.
// Assumes requests change at the falling clock edge.
`default_nettype none
module fgr_host
	import fgr_pkg::*;
(
	// Clock
	input  wire logic       clk_i,
	// Host bus
	output var fgr_io_req_type io_req_o,
	input  wire logic [7:0] io_rdata_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial io_req_o = '{rd: 1'b0, wr: 1'b0, addr: 16'h0000, wdata: 8'h00};
	// One strobe edge, then the idle bus shows the inverse of the last value
	task automatic cycle(input logic r, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge clk_i);
		io_req_o = '{rd: r, wr: !r, addr: a, wdata: d};
		@(negedge clk_i);
		io_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		cycle(1'b0, a, d);
	endtask
	task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
		cycle(1'b1, a, 8'h00);
		d = io_rdata_i;
	endtask
endmodule
`default_nettype wire

// ### verification/fgr_port_assertions.sv
// Checker bound to the fast gate port.
// Assumes the port's own clock and reset.
`default_nettype none
module fgr_port_assertions
	import fgr_pkg::*;
#(
	parameter int DELAY_CYC = RST_DELAY_CYC,
	parameter int WIDTH_CYC = RST_WIDTH_CYC
) (
	// Clock, reset, host
	input wire logic           clk_i,
	input wire logic           rst_i,
	input wire fgr_io_req_type io_req_i,
	input wire logic           io_hit_o,
	input wire logic [7:0]     io_rdata_o,
	// Pins
	input wire logic [7:0]     fast_reset_a20_config_i,
	input wire logic           kbd_reset_invert_i,
	input wire logic           kbc_port_bit_twentyone_i,
	input wire logic           alt_addr20_gate_o,
	input wire logic           alt_cpu_reset_n_o,
	input wire logic           cpu_addr20_mask_n_o,
	input wire logic           keyboard_reset_out_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Shadow of bit 0, pending arm, cycle counts
	// ----
	logic        b0_reg, b0_next, pend_reg, pend_next, wr, arm;
	logic [15:0] since_reg, since_next, low_reg, low_next;
	assign wr  = io_hit_o && io_req_i.wr;
	assign arm = wr && io_req_i.wdata[0] && !b0_reg;
	always_comb begin
		b0_next    = wr ? io_req_i.wdata[0] : b0_reg;
		pend_next  = arm || (pend_reg && alt_cpu_reset_n_o);
		since_next = arm ? 16'h0000 : since_reg + 16'h0001;
		low_next   = alt_cpu_reset_n_o ? 16'h0000 : low_reg + 16'h0001;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			b0_reg    <= 1'b0;
			pend_reg  <= 1'b0;
			since_reg <= 16'h0000;
			low_reg   <= 16'h0000;
		end else begin
			b0_reg    <= b0_next;
			pend_reg  <= pend_next;
			since_reg <= since_next;
			low_reg   <= low_next;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_wr; wr; endsequence
	sequence s_lo4;
		(!kbc_port_bit_twentyone_i && !alt_addr20_gate_o) [*4];
	endsequence
	property p_off;
		!fast_reset_a20_config_i[FGR_CFG_EN_BIT] |-> !io_hit_o;
	endproperty
	a_off: assert property (p_off) else $error("hit while off");
	property p_fix;
		(io_rdata_o & FGR_FIXED_MASK) == FGR_FIXED_VALUE;
	endproperty
	a_fix: assert property (p_fix) else $error("fixed bits");
	property p_a20;
		s_wr |=> alt_addr20_gate_o == $past(io_req_i.wdata[1]);
	endproperty
	a_a20: assert property (p_a20) else $error("a20 gate");
	property p_rd;
		io_hit_o && io_req_i.rd && !io_req_i.wr |=>
			io_rdata_o[1] == $past(alt_addr20_gate_o) &&
			io_rdata_o[0] == $past(b0_reg);
	endproperty
	a_rd: assert property (p_rd) else $error("readback");
	property p_dly;
		$fell(alt_cpu_reset_n_o) |-> pend_reg && since_reg >= DELAY_CYC;
	endproperty
	a_dly: assert property (p_dly) else $error("delay");
	property p_wid;
		$rose(alt_cpu_reset_n_o) |-> low_reg >= WIDTH_CYC;
	endproperty
	a_wid: assert property (p_wid) else $error("width");
	property p_mask;
		s_lo4 |-> !cpu_addr20_mask_n_o;
	endproperty
	a_mask: assert property (p_mask) else $error("mask");
	property p_kres;
		fast_reset_a20_config_i[FGR_CFG_EN_BIT] && !alt_cpu_reset_n_o |=>
			keyboard_reset_out_o == $past(kbd_reset_invert_i);
	endproperty
	a_kres: assert property (p_kres) else $error("kb reset");
endmodule

bind fgr_port fgr_port_assertions #(
	.DELAY_CYC(DELAY_CYC),
	.WIDTH_CYC(WIDTH_CYC)
) u_chk (.*);
`default_nettype wire

// ### verification/tb_fgr_port.sv
// Self-checking bench for the fast gate port.
// Assumes the host model and the bound checker.
`default_nettype none
module tb_fgr_port
	import fgr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int  DLY = 5;
	localparam int  WID = 3;
	logic           clk_i = 1'b0;
	logic           rst_i = 1'b1;
	fgr_io_req_type io_req;
	logic [7:0]     rdata, rd_v;
	logic [7:0]     cfg = 8'h00;
	logic           inv = 1'b0, p21 = 1'b0, kbc_n = 1'b1;
	logic           a20, alt_n, mask_n, kres, hit;
	int             n_mismatch = 0;
	int             num_checks = 0;
	fgr_host u_host (.clk_i(clk_i), .io_req_o(io_req), .io_rdata_i(rdata));
	fgr_port #(.DELAY_CYC(DLY), .WIDTH_CYC(WID)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .io_req_i(io_req), .io_hit_o(hit),
		.io_rdata_o(rdata), .fast_reset_a20_config_i(cfg),
		.kbd_reset_invert_i(inv), .kbc_port_bit_twentyone_i(p21),
		.kbc_reset_n_i(kbc_n), .alt_addr20_gate_o(a20),
		.alt_cpu_reset_n_o(alt_n), .cpu_addr20_mask_n_o(mask_n),
		.keyboard_reset_out_o(kres));
	initial forever #5 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic rd_chk(input logic [7:0] e);
		u_host.io_rd(FGR_PORT_ADDR, rd_v);
		chk("port", e, rd_v);
	endtask
	// Arm bit 0, then time the low pulse on the falling edges
	task automatic pulse_run(input logic exp_p);
		int d;
		int w;
		d = 0;
		w = 0;
		u_host.io_wr(FGR_PORT_ADDR, 8'h01);
		while (alt_n === 1'b1 && d < 40) begin
			@(negedge clk_i);
			d++;
		end
		chk("pulse", 8'(exp_p), 8'(d < 40));
		if (!exp_p) return;
		chk("delay", 8'h01, 8'(d >= DLY));
		while (alt_n === 1'b0 && w < 40) begin
			@(negedge clk_i);
			w++;
			if (w == 1) chk("kres", 8'(inv), 8'(kres));
		end
		chk("width", 8'h01, 8'(w >= WID));
	endtask
	initial begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk("alt_idle", 8'h01, 8'(alt_n));
		chk("a20_idle", 8'h00, 8'(a20));
		u_host.io_wr(FGR_PORT_ADDR, 8'h02);
		chk("a20_off", 8'h00, 8'(a20));
		cfg = 8'h04;
		rd_chk(FGR_PORT_RESET);
		u_host.io_wr(FGR_PORT_ADDR, 8'hFE);
		chk("a20_on", 8'h01, 8'(a20));
		rd_chk(8'h26);
		u_host.io_wr(16'h0093, 8'h00);
		rd_chk(8'h26);
		for (int i = 0; i < 4; i++) begin
			p21 = i[1];
			u_host.io_wr(FGR_PORT_ADDR, {6'h00, i[0], 1'b0});
			repeat (4) @(negedge clk_i);
			chk("mask", 8'(i != 0), 8'(mask_n));
		end
		pulse_run(1'b1);
		rd_chk(8'h25);
		pulse_run(1'b0);
		u_host.io_wr(FGR_PORT_ADDR, 8'h00);
		inv = 1'b1;
		pulse_run(1'b1);
		cfg = 8'h00;
		kbc_n = 1'b0;
		repeat (4) @(negedge clk_i);
		chk("kres_off", 8'h01, 8'(kres));
		cfg = 8'h04;
		u_host.io_wr(FGR_PORT_ADDR, 8'h03);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk("a20_rst", 8'h00, 8'(a20));
		rd_chk(FGR_PORT_RESET);
		repeat (20) @(negedge clk_i);
		chk("alt_rst", 8'h01, 8'(alt_n));
		kbc_n = 1'b1;
		repeat (4) @(negedge clk_i);
		chk("kres_idle", 8'h00, 8'(kres));
		conclude();
	end
	// Tests need about 140 cycles; allow over ten times that
	initial begin
		#20000;
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
